//--- src/swb_pkg.sv
// constants and types of the single-wire sensor bus transaction layer
package swb_pkg;

    // ========================================================
    // field widths and fixed values
    localparam int DEVNUM_W = 3;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam logic [2:0] BCAST_NUM = 3'h0;
    localparam logic [2:0] STRAP_LO_NUM = 3'h1;
    localparam logic [2:0] STRAP_HI_NUM = 3'h2;
    localparam logic [5:0] DEV_CTRL_ADDR = 6'h03;
    localparam logic [5:0] DEV_STATUS_ADDR = 6'h04;

    // ========================================================
    // bit counts
    localparam logic [4:0] DEVNUM_LAST = 5'h02;
    localparam logic [4:0] ADDR_LAST = 5'h05;
    localparam logic [4:0] NARROW_BITS = 5'h08;
    localparam logic [4:0] WIDE_BITS = 5'h10;
    localparam logic [3:0] TRAIN_BITS = 4'h8;
    localparam logic [3:0] ATTN_HOLDOFF_BITS = 4'hE;

    // ========================================================
    // local software port map and reset values
    localparam logic [1:0] SW_CTRL = 2'h0;
    localparam logic [1:0] SW_STATUS = 2'h1;
    localparam int CTRL_ATTN_EN_BIT = 0;
    localparam int STAT_BER_BIT = 0;
    localparam int STAT_BLOCK_BIT = 1;
    localparam int STAT_DEVNUM_LSB = 2;
    localparam logic CTRL_ATTN_EN_RESET = 1'b0;

    // ========================================================
    // types
    typedef enum logic [2:0] {
        SYM_DATA0 = 3'b000,
        SYM_DATA1 = 3'b001,
        SYM_START = 3'b010,
        SYM_ATTN = 3'b011,
        SYM_RESET = 3'b100,
        SYM_CONFLICT = 3'b101
    } sym_code_t;

    typedef struct packed {
        logic valid;
        sym_code_t code;
    } sym_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_TRAIN = 4'b0001,
        ST_DEVNUM = 4'b0010,
        ST_ADDR = 4'b0011,
        ST_DIR = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WPAR = 4'b0110,
        ST_WACK = 4'b0111,
        ST_RDATA = 4'b1000,
        ST_RPAR = 4'b1001,
        ST_RACK = 4'b1010,
        ST_SKIP = 4'b1011
    } state_t;

endpackage

//--- src/swb_transaction.sv
// device-side transaction layer of the single-wire sensor bus
// ============================================================
`timescale 1ns/1ns

module swb_transaction (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic addr_strap,
    input wire swb_pkg::sym_t sym,
    input wire logic bus_idle,
    input wire logic func_flag,
    input wire logic reg_wide,
    input wire logic [15:0] reg_rdata,
    input wire logic [1:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output swb_pkg::reg_req_t reg_req,
    output logic tx_active,
    output logic tx_drive,
    output logic attn_req,
    output logic bus_error_flag,
    output logic [7:0] sw_rdata
);

    // ========================================================
    // declarations
    swb_pkg::state_t state;
    logic [4:0] bit_cnt;
    logic [4:0] data_len;
    logic [2:0] dev_sh;
    logic [5:0] addr_sh;
    logic [15:0] data_sh;
    logic par;
    logic conflict;
    logic ack_ok;
    logic ber_set;
    logic status_read;
    logic [2:0] dev_num;
    logic strap_taken;
    logic attn_en;
    logic fn_block;
    logic pend_ber;
    logic [3:0] holdoff;
    logic bit_val;
    logic [4:0] next_cnt;
    logic [2:0] next_dev;
    logic addressed;
    logic bcast_ctrl;

    // true for symbols that carry a clean data bit
    function automatic logic is_data(input swb_pkg::sym_t s);
        is_data = s.valid && (s.code == swb_pkg::SYM_DATA0 || s.code == swb_pkg::SYM_DATA1);
    endfunction

    // true for a symbol of one given kind
    function automatic logic is_sym(input swb_pkg::sym_t s, input swb_pkg::sym_code_t c);
        is_sym = s.valid && (s.code == c);
    endfunction

    // ========================================================
    // decode helpers
    always_comb
    begin
        bit_val = (sym.code == swb_pkg::SYM_DATA1);
        next_cnt = bit_cnt + 5'h01;
        next_dev = {dev_sh[1:0], bit_val};
        addressed = (dev_sh == dev_num);
        bcast_ctrl = (dev_sh == swb_pkg::BCAST_NUM) && (reg_req.addr == swb_pkg::DEV_CTRL_ADDR);
    end

    // ========================================================
    // strap capture after reset release; async reset loads only a constant
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            dev_num <= swb_pkg::BCAST_NUM;
            strap_taken <= 1'b0;
        end
        else if (!strap_taken)
        begin
            dev_num <= addr_strap ? swb_pkg::STRAP_HI_NUM : swb_pkg::STRAP_LO_NUM;
            strap_taken <= 1'b1;
        end
    end

    // ========================================================
    // transaction sequencer
    // a bus reset only touches this process and the attention gating, never
    // the control register or the register map outside
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= swb_pkg::ST_IDLE;
            bit_cnt <= 5'h00;
            data_len <= swb_pkg::NARROW_BITS;
            dev_sh <= 3'h0;
            addr_sh <= 6'h00;
            data_sh <= 16'h0000;
            par <= 1'b0;
            conflict <= 1'b0;
            ack_ok <= 1'b0;
            ber_set <= 1'b0;
            status_read <= 1'b0;
            reg_req <= '0;
            tx_active <= 1'b0;
            tx_drive <= 1'b0;
        end
        else
        begin
            reg_req.wr <= 1'b0;
            reg_req.rd <= 1'b0;
            ber_set <= 1'b0;
            status_read <= 1'b0;
            // read data arrive with the read strobe; narrow data left-aligned
            // so only the register's own width is shifted out
            if (reg_req.rd)
            begin
                data_sh <= reg_wide ? reg_rdata : {reg_rdata[7:0], 8'h00};
                tx_drive <= reg_wide ? reg_rdata[15] : reg_rdata[7];
                tx_active <= 1'b1;
            end
            if (is_sym(sym, swb_pkg::SYM_RESET))
            begin
                // reset end seen: eight training bits follow, then idle
                state <= swb_pkg::ST_TRAIN;
                bit_cnt <= 5'h00;
                tx_active <= 1'b0;
            end
            else if (is_sym(sym, swb_pkg::SYM_START))
            begin
                // abort whatever runs, no error, no attention
                state <= swb_pkg::ST_DEVNUM;
                bit_cnt <= 5'h00;
                par <= 1'b0;
                conflict <= 1'b0;
                tx_active <= 1'b0;
            end
            else if (is_sym(sym, swb_pkg::SYM_CONFLICT))
            begin
                // the collided bit is dropped and the slot waits for the resend
                conflict <= 1'b1;
            end
            else if (is_data(sym))
            begin
                case (state)
                    swb_pkg::ST_TRAIN:
                    begin
                        bit_cnt <= next_cnt;
                        if (bit_cnt[3:0] == swb_pkg::TRAIN_BITS - 4'h1)
                        begin
                            state <= swb_pkg::ST_IDLE;
                        end
                    end
                    swb_pkg::ST_DEVNUM:
                    begin
                        dev_sh <= next_dev;
                        par <= par ^ bit_val;
                        bit_cnt <= next_cnt;
                        if (bit_cnt == swb_pkg::DEVNUM_LAST)
                        begin
                            state <= swb_pkg::ST_ADDR;
                            bit_cnt <= 5'h00;
                        end
                    end
                    swb_pkg::ST_ADDR:
                    begin
                        addr_sh <= {addr_sh[4:0], bit_val};
                        par <= par ^ bit_val;
                        bit_cnt <= next_cnt;
                        if (bit_cnt == swb_pkg::ADDR_LAST)
                        begin
                            reg_req.addr <= {addr_sh[4:0], bit_val};
                            state <= swb_pkg::ST_DIR;
                            bit_cnt <= 5'h00;
                        end
                    end
                    swb_pkg::ST_DIR:
                    begin
                        par <= par ^ bit_val;
                        // width comes from the map for the address just seen
                        data_len <= reg_wide ? swb_pkg::WIDE_BITS : swb_pkg::NARROW_BITS;
                        if (bit_val)
                        begin
                            state <= addressed ? swb_pkg::ST_RDATA : swb_pkg::ST_SKIP;
                            reg_req.rd <= addressed;
                        end
                        else
                        begin
                            state <= (addressed || bcast_ctrl) ? swb_pkg::ST_WDATA : swb_pkg::ST_SKIP;
                        end
                    end
                    swb_pkg::ST_WDATA:
                    begin
                        data_sh <= {data_sh[14:0], bit_val};
                        par <= par ^ bit_val;
                        bit_cnt <= next_cnt;
                        if (next_cnt == data_len)
                        begin
                            state <= swb_pkg::ST_WPAR;
                        end
                    end
                    swb_pkg::ST_WPAR:
                    begin
                        // surplus data bits land here and usually spoil parity
                        ack_ok <= ((par ^ bit_val) == 1'b0) && !conflict;
                        tx_drive <= ((par ^ bit_val) == 1'b0) && !conflict;
                        tx_active <= 1'b1;
                        reg_req.wdata <= data_len == swb_pkg::WIDE_BITS ? data_sh : {8'h00, data_sh[7:0]};
                        state <= swb_pkg::ST_WACK;
                    end
                    swb_pkg::ST_WACK:
                    begin
                        tx_active <= 1'b0;
                        tx_drive <= 1'b0;
                        reg_req.wr <= ack_ok;
                        ber_set <= !ack_ok;
                        state <= swb_pkg::ST_IDLE;
                    end
                    swb_pkg::ST_RDATA:
                    begin
                        // parity runs over what was driven, not what was heard
                        par <= par ^ tx_drive;
                        data_sh <= {data_sh[14:0], 1'b0};
                        bit_cnt <= next_cnt;
                        if (next_cnt == data_len)
                        begin
                            tx_drive <= par ^ tx_drive;
                            state <= swb_pkg::ST_RPAR;
                        end
                        else
                        begin
                            tx_drive <= data_sh[14];
                        end
                    end
                    swb_pkg::ST_RPAR:
                    begin
                        tx_active <= 1'b0;
                        tx_drive <= 1'b0;
                        state <= swb_pkg::ST_RACK;
                    end
                    swb_pkg::ST_RACK:
                    begin
                        // a zero from the master means the read did not complete
                        ber_set <= !bit_val;
                        status_read <= bit_val && (reg_req.addr == swb_pkg::DEV_STATUS_ADDR);
                        state <= swb_pkg::ST_IDLE;
                    end
                    default:
                    begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // ========================================================
    // attention gating
    // counts master data bits after bus reset; attention is held off until 14
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            holdoff <= 4'h0;
        end
        else if (is_sym(sym, swb_pkg::SYM_RESET))
        begin
            holdoff <= 4'h0;
        end
        else if (is_data(sym) && holdoff != swb_pkg::ATTN_HOLDOFF_BITS)
        begin
            holdoff <= holdoff + 4'h1;
        end
    end

    // a pending bus error survives status reads but not a bus reset
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pend_ber <= 1'b0;
        end
        else if (ber_set)
        begin
            pend_ber <= 1'b1;
        end
        else if (is_sym(sym, swb_pkg::SYM_RESET) || (is_sym(sym, swb_pkg::SYM_ATTN) && attn_req))
        begin
            pend_ber <= 1'b0;
        end
    end

    // any attention on the bus blocks function attention until status is read
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            fn_block <= 1'b0;
        end
        else if (is_sym(sym, swb_pkg::SYM_ATTN))
        begin
            fn_block <= 1'b1;
        end
        else if (status_read || is_sym(sym, swb_pkg::SYM_RESET))
        begin
            fn_block <= 1'b0;
        end
    end

    // request follows its sources while the bus idles; cleared when the bit layer reports an attention or a bus reset
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            attn_req <= 1'b0;
        end
        else if (sym.valid && (sym.code == swb_pkg::SYM_ATTN || sym.code == swb_pkg::SYM_RESET))
        begin
            attn_req <= 1'b0;
        end
        else if (bus_idle && holdoff == swb_pkg::ATTN_HOLDOFF_BITS)
        begin
            attn_req <= pend_ber || (func_flag && attn_en && !fn_block);
        end
    end

    // ========================================================
    // error flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_error_flag <= 1'b0;
        end
        else if (ber_set)
        begin
            bus_error_flag <= 1'b1;
        end
        else if (sw_wr && sw_addr == swb_pkg::SW_STATUS && sw_wdata[swb_pkg::STAT_BER_BIT])
        begin
            bus_error_flag <= 1'b0;
        end
    end

    // ========================================================
    // local software port: control write, register readback
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            attn_en <= swb_pkg::CTRL_ATTN_EN_RESET;
        end
        else if (sw_wr && sw_addr == swb_pkg::SW_CTRL)
        begin
            attn_en <= sw_wdata[swb_pkg::CTRL_ATTN_EN_BIT];
        end
    end

    // read data stand one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sw_rdata <= 8'h00;
        end
        else if (sw_rd && sw_addr == swb_pkg::SW_CTRL)
        begin
            sw_rdata <= {7'h00, attn_en};
        end
        else if (sw_rd && sw_addr == swb_pkg::SW_STATUS)
        begin
            sw_rdata <= {3'h0, dev_num, fn_block, bus_error_flag};
        end
        else
        begin
            sw_rdata <= 8'h00;
        end
    end

endmodule // swb_transaction

//--- testbench/swb_master_model.sv
// bus master and register map model facing the transaction layer
`timescale 1ns/1ns

module swb_master_model (
    input wire logic mclk,
    input wire swb_pkg::reg_req_t reg_req,
    output swb_pkg::sym_t sym,
    output logic reg_wide,
    output logic [15:0] reg_rdata
);
    logic [15:0] rd_val;

    // =====
    // register map: bit 5 of the address marks a wide register
    assign reg_wide = reg_req.addr[5];
    // data only while the read strobe stands, garbage otherwise
    assign reg_rdata = reg_req.rd ? rd_val : ~rd_val;

    initial
    begin
        sym = '0;
        rd_val = 16'h0000;
    end

    // one bit signal: a one-cycle pulse, then quiet cycles so a read slot has time to load
    task automatic send(input swb_pkg::sym_code_t c);
        @(posedge mclk);
        sym <= {1'b1, c};
        @(posedge mclk);
        sym <= '0;
        repeat (3) @(posedge mclk);
        #1;
    endtask
endmodule // swb_master_model

//--- testbench/swb_transaction_asserts.sv
// concurrent checks on the ports of the transaction layer
`timescale 1ns/1ns

module swb_transaction_asserts (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic addr_strap,
    input wire logic bus_idle,
    input wire swb_pkg::sym_t sym,
    input wire logic [1:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    input wire swb_pkg::reg_req_t reg_req,
    input wire logic tx_active,
    input wire logic tx_drive,
    input wire logic attn_req,
    input wire logic bus_error_flag,
    input wire logic [7:0] sw_rdata
);
    logic [3:0] bits_seen;
    logic ber_clr;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    // =====
    // data bits since bus reset, saturating so it never wraps back under the hold-off
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            bits_seen <= 4'h0;
        else if (sym.valid && sym.code == swb_pkg::SYM_RESET)
            bits_seen <= 4'h0;
        else if (sym.valid && sym.code inside {swb_pkg::SYM_DATA0, swb_pkg::SYM_DATA1} && bits_seen != 4'hF)
            bits_seen <= bits_seen + 4'h1;
    end
    assign ber_clr = sw_wr && sw_addr == swb_pkg::SW_STATUS && sw_wdata[0];

    // =====
    // properties
    property p_holdoff; $rose(attn_req) |-> bits_seen >= 4'hE; endproperty
    a_holdoff: assert property (p_holdoff) else $error("attention before hold-off");
    property p_idle; $rose(attn_req) |-> $past(bus_idle); endproperty
    a_idle: assert property (p_idle) else $error("attention on a busy bus");
    property p_drop; sym.valid && sym.code inside {swb_pkg::SYM_ATTN, swb_pkg::SYM_RESET} |-> ##[1:2] !attn_req;
    endproperty
    a_drop: assert property (p_drop) else $error("attention not withdrawn");
    property p_rd_tx; reg_req.rd |=> tx_active; endproperty
    a_rd_tx: assert property (p_rd_tx) else $error("read slot not owned");
    property p_wr_ack; reg_req.wr |-> $past(tx_active) && $past(tx_drive); endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write without positive ack");
    property p_abort; sym.valid && sym.code == swb_pkg::SYM_START |=> !tx_active; endproperty
    a_abort: assert property (p_abort) else $error("start did not abort");
    property p_ber; bus_error_flag && !ber_clr |=> bus_error_flag; endproperty
    a_ber: assert property (p_ber) else $error("error flag lost");
    property p_quiet; !sw_rd |=> sw_rdata == 8'h00; endproperty
    a_quiet: assert property (p_quiet) else $error("read data outside slot");
    property p_devnum; sw_rd && sw_addr == swb_pkg::SW_STATUS |=>
        sw_rdata[7:2] == {3'h0, (addr_strap ? swb_pkg::STRAP_HI_NUM : swb_pkg::STRAP_LO_NUM)}; endproperty
    a_devnum: assert property (p_devnum) else $error("device number wrong");
    property p_hold; tx_active && !sym.valid |=> $stable(tx_drive); endproperty
    a_hold: assert property (p_hold) else $error("slot value moved");

    c_wr: cover property (reg_req.wr);
    c_rd: cover property (reg_req.rd);
    c_attn: cover property ($rose(attn_req));
    c_ber: cover property ($rose(bus_error_flag));
endmodule // swb_transaction_asserts

bind swb_transaction swb_transaction_asserts u_chk (.mclk(mclk), .rstn(rstn), .addr_strap(addr_strap),
    .bus_idle(bus_idle), .sym(sym), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .reg_req(reg_req), .tx_active(tx_active), .tx_drive(tx_drive), .attn_req(attn_req),
    .bus_error_flag(bus_error_flag), .sw_rdata(sw_rdata));

//--- testbench/tb_swb_transaction.sv
// self-checking bench for the sensor bus transaction layer
`timescale 1ns/1ns

module tb_swb_transaction;
    localparam logic [12:0] PART = 13'h0455;
    logic mclk, rstn, bus_idle, func_flag, sw_wr, sw_rd, rd_seen, addr_strap;
    logic [1:0] sw_addr;
    logic [7:0] sw_wdata;
    logic [7:0] sw_rdata;
    logic reg_wide, tx_active, tx_drive, attn_req, bus_error_flag;
    logic [15:0] reg_rdata;
    logic [31:0] seed;
    swb_pkg::sym_t sym;
    swb_pkg::reg_req_t reg_req;
    swb_pkg::reg_req_t rq[$];
    logic [7:0] swq[$];
    int fails, cmp_count;

    swb_transaction u_dut (.mclk(mclk), .rstn(rstn), .addr_strap(addr_strap), .sym(sym), .bus_idle(bus_idle),
        .func_flag(func_flag), .reg_wide(reg_wide), .reg_rdata(reg_rdata), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .reg_req(reg_req), .tx_active(tx_active),
        .tx_drive(tx_drive), .attn_req(attn_req), .bus_error_flag(bus_error_flag), .sw_rdata(sw_rdata));
    swb_master_model u_mst (.mclk(mclk), .reg_req(reg_req), .sym(sym), .reg_wide(reg_wide),
        .reg_rdata(reg_rdata));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // =====
    // helpers
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        chk(16'(rq.size() + swq.size()), 16'h0000);
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic dbit(input logic b);
        u_mst.send(b ? swb_pkg::SYM_DATA1 : swb_pkg::SYM_DATA0);
    endtask

    task automatic sw_acc(input logic wr, input logic [1:0] a, input logic [7:0] d);
        if (!wr)
            swq.push_back(d);
        @(posedge mclk);
        sw_wr <= wr;
        sw_rd <= !wr;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge mclk);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
    endtask

    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_attn(input logic e);
        #1;
        for (int n = 0; n < 40 && attn_req !== e; n++)
            @(posedge mclk) #1;
        chk(attn_req, e);
        if (attn_req !== e)
            report_and_stop();
    endtask

    // one transaction; bad: 0 clean, 1 parity or ack wrong, 2 collision before parity
    task automatic frame(input logic [2:0] dv, input logic [5:0] ad, input logic rw, input logic [15:0] d,
        input int bad, input logic hit);
        int n;
        logic p;
        logic [15:0] dd;
        logic [9:0] hd;
        n = ad[5] ? 16 : 8;
        hd = {dv, ad, rw};
        dd = ad[5] ? d : {8'h00, d[7:0]};
        p = ^{hd, dd};
        u_mst.rd_val = d;
        if (hit && (bad == 0 || rw))
            rq.push_back({~rw, rw, ad, dd});
        u_mst.send(swb_pkg::SYM_START);
        for (int i = 9; i >= 0; i--)
            dbit(hd[i]);
        for (int i = n - 1; i >= 0; i--)
        begin
            if (hit && rw)
            begin
                chk(tx_active, 1'b1);
                chk(tx_drive, dd[i]);
            end
            dbit(dd[i] & (hit | !rw));
        end
        if (rw)
        begin
            if (hit)
                chk(tx_drive, p);
            dbit(p & hit);
            chk(tx_active, 1'b0);
            dbit(bad == 0);
        end
        else
        begin
            if (bad == 2)
                u_mst.send(swb_pkg::SYM_CONFLICT);
            dbit(p ^ (bad == 1));
            chk(tx_active, hit);
            if (hit)
                chk(tx_drive, bad == 0);
            dbit(hit && bad == 0);
        end
        chk(bus_error_flag, hit && bad != 0);
    endtask

    // =====
    // monitor: strobes and read data are compared with the oldest note
    always @(posedge mclk)
    begin
        if (rd_seen)
            chk(sw_rdata, swq.pop_front());
        rd_seen <= sw_rd;
        if (reg_req.wr || reg_req.rd)
        begin
            if (rq.size() == 0)
                chk(16'h0001, 16'h0000);
            else
            begin
                chk({reg_req.wr, reg_req.rd, reg_req.addr}, {rq[0].wr, rq[0].rd, rq[0].addr});
                if (rq[0].wr)
                    chk(reg_req.wdata, rq[0].wdata);
                void'(rq.pop_front());
            end
        end
    end

    // =====
    // main sequence
    initial
    begin
        seed = 32'h8467DAD8;
        fails = 0;
        cmp_count = 0;
        {rstn, bus_idle, func_flag, sw_wr, sw_rd, addr_strap} = '0;
        sw_addr = 2'h0;
        sw_wdata = 8'h00;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        sw_acc(1'b0, swb_pkg::SW_STATUS, 8'h04);
        sw_acc(1'b0, 2'h3, 8'h00);
        sw_acc(1'b1, swb_pkg::SW_CTRL, 8'h01);
        u_mst.send(swb_pkg::SYM_RESET);
        sw_acc(1'b0, swb_pkg::SW_CTRL, 8'h01);
        func_flag <= 1'b1;
        bus_idle <= 1'b1;
        repeat (8) dbit(1'b0);
        wait_attn(1'b0);
        bus_idle <= 1'b0;
        frame(3'h1, 6'h05, 1'b0, 16'(lfsr()), 0, 1'b1);
        bus_idle <= 1'b1;
        wait_attn(1'b1);
        u_mst.send(swb_pkg::SYM_ATTN);
        repeat (10) @(posedge mclk);
        wait_attn(1'b0);
        sw_acc(1'b0, swb_pkg::SW_STATUS, 8'h06);
        bus_idle <= 1'b0;
        frame(3'h1, 6'h21, 1'b0, 16'(lfsr()), 1, 1'b1);
        frame(3'h1, 6'h06, 1'b0, 16'(lfsr()), 2, 1'b1);
        bus_idle <= 1'b1;
        wait_attn(1'b1);
        u_mst.send(swb_pkg::SYM_ATTN);
        sw_acc(1'b1, swb_pkg::SW_STATUS, 8'h01);
        sw_acc(1'b0, swb_pkg::SW_STATUS, 8'h06);
        bus_idle <= 1'b0;
        frame(3'h1, swb_pkg::DEV_STATUS_ADDR, 1'b1, 16'(lfsr()), 0, 1'b1);
        bus_idle <= 1'b1;
        wait_attn(1'b1);
        u_mst.send(swb_pkg::SYM_ATTN);
        func_flag <= 1'b0;
        bus_idle <= 1'b0;
        frame(3'h1, 6'h2A, 1'b1, 16'(lfsr()), 0, 1'b1);
        frame(3'h1, 6'h3F, 1'b1, 16'(lfsr()), 1, 1'b1);
        sw_acc(1'b1, swb_pkg::SW_STATUS, 8'h01);
        frame(3'h0, 6'h2A, 1'b1, 16'(lfsr()), 0, 1'b0);
        frame(3'h0, swb_pkg::DEV_CTRL_ADDR, 1'b0, 16'(lfsr()), 0, 1'b1);
        frame(3'h0, 6'h05, 1'b0, 16'(lfsr()), 0, 1'b0);
        frame(3'h2, 6'h05, 1'b0, 16'(lfsr()), 0, 1'b0);
        // a write cut short after three data bits, then a fresh start
        u_mst.send(swb_pkg::SYM_START);
        for (int i = 12; i >= 0; i--)
            dbit(PART[i]);
        frame(3'h1, 6'h27, 1'b0, 16'(lfsr()), 0, 1'b1);
        repeat (4) @(posedge mclk);
        // power reset with the strap high: number 2, control back to its reset value
        rstn <= 1'b0;
        addr_strap <= 1'b1;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        sw_acc(1'b0, swb_pkg::SW_STATUS, 8'h08);
        sw_acc(1'b0, swb_pkg::SW_CTRL, 8'h00);
        frame(3'h2, 6'h25, 1'b1, 16'(lfsr()), 0, 1'b1);
        repeat (4) @(posedge mclk);
        report_and_stop();
    end
endmodule // tb_swb_transaction
